// [smta_pkg.sv]
// Constants for the static / reserved multicast table access register bank.
// Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
// What this block does
// - With the reserved multicast table selected, the whole six-bit index at control bits 21:16 picks the entry.
// - With the static address table selected, only index bits 19:16 pick the entry and the upper bits are ignored.
// - Software writes one to control bit 7 to start an access and the device clears it when the access is done.
// - Control bit 1 picks the table: one is the reserved multicast table, zero the static address table.
// - Control bit 0 picks the direction: one reads the entry, zero writes it.
// - Static address table accesses move the entry through all four entry registers at 0x0420 to 0x042f.
// - Reserved multicast table accesses move the entry through the second entry register at 0x0424 only.
// - The meaning of the entry register bits follows the format of the table being accessed.
// - The entry registers are shared between address lookup and static address table accesses.
package smta_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_WORDS = 4;
  localparam int IDX_W = 6;

  // Register byte offsets
  localparam logic [15:0] OFS_CTRL = 16'h041c;
  localparam logic [15:0] OFS_ENTRY1 = 16'h0420;
  localparam logic [15:0] OFS_ENTRY2 = 16'h0424;
  localparam logic [15:0] OFS_ENTRY3 = 16'h0428;
  localparam logic [15:0] OFS_ENTRY4 = 16'h042c;

  // Control register field positions
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_SPARE_LSB = 2;
  localparam int CTRL_SPARE_MSB = 6;
  localparam int CTRL_GO_BIT = 7;
  localparam int CTRL_IDX_LSB = 16;
  localparam int CTRL_IDX_MSB = 21;
  localparam int STATIC_IDX_W = 4;

  // Entry word that carries the reserved multicast table value
  localparam int MCAST_WORD = 1;

  // Reset values
  localparam logic [5:0] RST_IDX = 6'h00;
  localparam logic [4:0] RST_SPARE = 5'h00;
  localparam logic [31:0] RST_ENTRY = 32'h0000_0000;

  // Table and direction codes
  localparam logic SEL_STATIC = 1'b0;
  localparam logic SEL_MCAST = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    SMTA_IDLE = 1'b0,
    SMTA_BUSY = 1'b1
  } smta_state_t;

endpackage

// [smta_top.sv]
// Table access register bank: control register, four shared entry registers,
// AXI4-Lite slave and a request/acknowledge port to the table storage.
// Assumes the table storage and the address lookup engine run on aclk.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module smta_top
  import smta_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Table storage port
  output logic tbl_req,
  output logic tbl_sel,
  output logic tbl_rd,
  output logic [5:0] tbl_index,
  output logic [31:0] tbl_wdata1,
  output logic [31:0] tbl_wdata2,
  output logic [31:0] tbl_wdata3,
  output logic [31:0] tbl_wdata4,
  input wire logic tbl_ack,
  input wire logic [31:0] tbl_rdata1,
  input wire logic [31:0] tbl_rdata2,
  input wire logic [31:0] tbl_rdata3,
  input wire logic [31:0] tbl_rdata4,
  // Address lookup engine sharing the entry registers
  input wire logic address_lookup_load,
  input wire logic [31:0] address_lookup_word1,
  input wire logic [31:0] address_lookup_word2,
  input wire logic [31:0] address_lookup_word3,
  input wire logic [31:0] address_lookup_word4,
  output logic [31:0] entry_word1,
  output logic [31:0] entry_word2,
  output logic [31:0] entry_word3,
  output logic [31:0] entry_word4,
  output logic access_busy
);

  smta_state_t state_reg;
  logic access_go_done_reg;
  logic sel_reg;
  logic dir_reg;
  logic [4:0] spare_reg;
  logic [5:0] idx_reg;
  logic [31:0] entry_reg [NUM_WORDS];

  logic aw_full_reg;
  logic w_full_reg;
  logic [15:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic tbl_req_reg;
  logic tbl_sel_reg;
  logic tbl_rd_reg;
  logic [5:0] tbl_index_reg;
  logic [31:0] tbl_wdata_reg [NUM_WORDS];

  // Bus decode
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire [15:0] wr_word = {wr_addr_reg[15:2], 2'h0};
  wire [15:0] rd_word = {s_axi_araddr[15:2], 2'h0};
  wire wr_ctrl = wr_fire & (wr_word == OFS_CTRL);
  wire [NUM_WORDS-1:0] wr_entry_hit;
  wire [NUM_WORDS-1:0] rd_entry_hit;
  wire [31:0] wr_mask;
  wire wr_mapped = (wr_word == OFS_CTRL) | (|wr_entry_hit);
  wire rd_mapped = (rd_word == OFS_CTRL) | (|rd_entry_hit);
  wire busy = (state_reg == SMTA_BUSY);

  // Control register image and merged write value
  wire [31:0] ctrl_image = {10'h000, idx_reg, 8'h00, access_go_done_reg, spare_reg, sel_reg, dir_reg};
  wire [31:0] ctrl_new = (ctrl_image & ~wr_mask) | (wr_data_reg & wr_mask);
  wire go_start = wr_ctrl & ~busy & ctrl_new[CTRL_GO_BIT];
  wire new_sel = ctrl_new[CTRL_SEL_BIT];
  wire [5:0] new_idx = ctrl_new[CTRL_IDX_MSB:CTRL_IDX_LSB];
  wire [5:0] eff_idx = (new_sel == SEL_MCAST) ? new_idx : {2'h0, new_idx[STATIC_IDX_W-1:0]};
  wire tbl_done = busy & tbl_req_reg & tbl_ack;
  wire load_rd = tbl_done & (tbl_rd_reg == DIR_READ);
  wire [31:0] tbl_rdata_w [NUM_WORDS];
  wire [31:0] alu_word_w [NUM_WORDS];
  logic [31:0] rd_value;

  assign tbl_rdata_w[0] = tbl_rdata1;
  assign tbl_rdata_w[1] = tbl_rdata2;
  assign tbl_rdata_w[2] = tbl_rdata3;
  assign tbl_rdata_w[3] = tbl_rdata4;
  assign alu_word_w[0] = address_lookup_word1;
  assign alu_word_w[1] = address_lookup_word2;
  assign alu_word_w[2] = address_lookup_word3;
  assign alu_word_w[3] = address_lookup_word4;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_mask
      assign wr_mask[gb*8 +: 8] = {8{wr_strb_reg[gb]}};
    end
  endgenerate

  always_comb begin
    rd_value = 32'h0000_0000;
    if (rd_word == OFS_CTRL) begin
      rd_value = ctrl_image;
    end
    for (int k = 0; k < NUM_WORDS; k++) begin
      if (rd_entry_hit[k]) begin
        rd_value = entry_reg[k];
      end
    end
  end

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_addr_reg <= 16'h0000;
      wr_data_reg <= 32'h0000_0000;
      wr_strb_reg <= 4'h0;
    end else if (ce) begin
      awready_reg <= ~aw_full_reg & ~aw_take & ~bvalid_reg;
      wready_reg <= ~w_full_reg & ~w_take & ~bvalid_reg;
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        awready_reg <= 1'b0;
        wready_reg <= 1'b0;
      end else if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_value;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end else begin
        arready_reg <= ~rvalid_reg;
      end
    end
  end

  // Control register and access sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SMTA_IDLE;
      access_go_done_reg <= 1'b0;
      sel_reg <= SEL_STATIC;
      dir_reg <= DIR_WRITE;
      spare_reg <= RST_SPARE;
      idx_reg <= RST_IDX;
      tbl_req_reg <= 1'b0;
      tbl_sel_reg <= SEL_STATIC;
      tbl_rd_reg <= DIR_WRITE;
      tbl_index_reg <= RST_IDX;
    end else if (ce) begin
      unique case (state_reg)
        SMTA_IDLE: begin
          if (wr_ctrl) begin
            idx_reg <= new_idx;
            spare_reg <= ctrl_new[CTRL_SPARE_MSB:CTRL_SPARE_LSB];
            sel_reg <= new_sel;
            dir_reg <= ctrl_new[CTRL_DIR_BIT];
          end
          if (go_start) begin
            access_go_done_reg <= 1'b1;
            state_reg <= SMTA_BUSY;
            tbl_req_reg <= 1'b1;
            tbl_sel_reg <= new_sel;
            tbl_rd_reg <= ctrl_new[CTRL_DIR_BIT];
            tbl_index_reg <= eff_idx;
          end
        end
        SMTA_BUSY: begin
          if (tbl_done) begin
            access_go_done_reg <= 1'b0;
            tbl_req_reg <= 1'b0;
            state_reg <= SMTA_IDLE;
          end
        end
      endcase
    end
  end

  // Entry registers, one per word
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WORDS; gw++) begin : g_entry
      localparam logic [15:0] WOFS = OFS_ENTRY1 + 16'(4 * gw);
      wire part = (tbl_sel_reg == SEL_STATIC) | (gw == MCAST_WORD);
      wire go_part = go_start & ((new_sel == SEL_STATIC) | (gw == MCAST_WORD));
      assign wr_entry_hit[gw] = wr_word == WOFS;
      assign rd_entry_hit[gw] = rd_word == WOFS;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          entry_reg[gw] <= RST_ENTRY;
          tbl_wdata_reg[gw] <= RST_ENTRY;
        end else if (ce) begin
          if (load_rd & part) begin
            entry_reg[gw] <= tbl_rdata_w[gw];
          end else if (address_lookup_load & ~busy) begin
            entry_reg[gw] <= alu_word_w[gw];
          end else if (wr_fire & wr_entry_hit[gw] & ~busy) begin
            entry_reg[gw] <= (entry_reg[gw] & ~wr_mask) | (wr_data_reg & wr_mask);
          end
          if (go_start) begin
            tbl_wdata_reg[gw] <= go_part ? entry_reg[gw] : RST_ENTRY;
          end
        end
      end
    end
  endgenerate

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tbl_req = tbl_req_reg;
  assign tbl_sel = tbl_sel_reg;
  assign tbl_rd = tbl_rd_reg;
  assign tbl_index = tbl_index_reg;
  assign tbl_wdata1 = tbl_wdata_reg[0];
  assign tbl_wdata2 = tbl_wdata_reg[1];
  assign tbl_wdata3 = tbl_wdata_reg[2];
  assign tbl_wdata4 = tbl_wdata_reg[3];
  assign entry_word1 = entry_reg[0];
  assign entry_word2 = entry_reg[1];
  assign entry_word3 = entry_reg[2];
  assign entry_word4 = entry_reg[3];
  assign access_busy = access_go_done_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mcast_index_a: assert property (tbl_req_reg & tbl_sel_reg |-> tbl_index_reg == idx_reg)
    else $error("multicast index differs from control index");
  static_index_a: assert property (tbl_req_reg & ~tbl_sel_reg |-> tbl_index_reg == {2'h0, idx_reg[3:0]})
    else $error("static index not limited to four bits");
  go_hold_a: assert property (access_go_done_reg & ~(ce & tbl_done) |=> access_go_done_reg)
    else $error("go bit cleared without completion");
  go_start_a: assert property (ce & go_start |=> access_go_done_reg & tbl_req_reg)
    else $error("access did not start");
  table_sel_a: assert property (tbl_req_reg |-> tbl_sel_reg == sel_reg)
    else $error("table select mismatch");
  dir_sel_a: assert property (tbl_req_reg |-> tbl_rd_reg == dir_reg)
    else $error("direction mismatch");
  static_load_a: assert property (ce & load_rd & ~tbl_sel_reg |=>
    entry_reg[0] == $past(tbl_rdata1) && entry_reg[3] == $past(tbl_rdata4))
    else $error("static read not loaded into all words");
  mcast_load_a: assert property (ce & load_rd & tbl_sel_reg |=>
    entry_reg[1] == $past(tbl_rdata2) && $stable(entry_reg[0]) && $stable(entry_reg[2]))
    else $error("multicast read touched other words");
  mcast_wdata_a: assert property (tbl_req_reg & tbl_sel_reg |-> tbl_wdata_reg[0] == 32'h0 && tbl_wdata_reg[3] == 32'h0)
    else $error("multicast write drove unused words");
  shared_load_a: assert property (ce & address_lookup_load & ~busy & ~load_rd |=> entry_reg[2] == $past(address_lookup_word3))
    else $error("lookup engine load lost");
  done_order_a: assert property ($fell(access_go_done_reg) |-> $past(tbl_req_reg) && $past(tbl_ack))
    else $error("go cleared before table acknowledged");

endmodule
`default_nettype wire

// [smta_top_tb.sv]
// Self-checking bench for the table access register bank.
// Drives AXI4-Lite as master and stands in for the table storage and lookup engine.
`timescale 1ns/100ps
`default_nettype none
module smta_top_tb;
  import smta_pkg::*;
  typedef struct packed {logic sel; logic rd; logic [5:0] idx; logic [4:0] spare;} smta_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tbl_req, tbl_sel, tbl_rd, access_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tbl_wdata1, tbl_wdata2, tbl_wdata3, tbl_wdata4;
  logic [31:0] entry_word1, entry_word2, entry_word3, entry_word4;
  logic [5:0] tbl_index;
  logic tbl_ack = 1'b0;
  logic address_lookup_load = 1'b0;
  logic [31:0] tbl_rdata1 = 32'h0, tbl_rdata2 = 32'h0, tbl_rdata3 = 32'h0, tbl_rdata4 = 32'h0;
  logic [31:0] address_lookup_word1 = 32'h0, address_lookup_word2 = 32'h0;
  logic [31:0] address_lookup_word3 = 32'h0, address_lookup_word4 = 32'h0;
  logic [31:0] pre [4];
  logic [31:0] rv [4];
  logic [31:0] ctrl, got;
  smta_row_t row;
  int mismatches = 0;
  int cmp_count = 0;
  // Table choice, direction, six-bit index, spare bits
  smta_row_t rows [6] = '{'{1'b0, 1'b0, 6'h3f, 5'h15}, '{1'b0, 1'b1, 6'h25, 5'h0a}, '{1'b1, 1'b0, 6'h3f, 5'h1f},
                          '{1'b1, 1'b1, 6'h2a, 5'h00}, '{1'b0, 1'b1, 6'h10, 5'h01}, '{1'b1, 1'b1, 6'h07, 5'h10}};

  smta_top smta_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tbl_req,
    .tbl_sel, .tbl_rd, .tbl_index, .tbl_wdata1, .tbl_wdata2, .tbl_wdata3, .tbl_wdata4, .tbl_ack, .tbl_rdata1,
    .tbl_rdata2, .tbl_rdata3, .tbl_rdata4, .address_lookup_load, .address_lookup_word1, .address_lookup_word2,
    .address_lookup_word3, .address_lookup_word4, .entry_word1, .entry_word2, .entry_word3, .entry_word4,
    .access_busy);

  always #2.5 aclk = ~aclk;

  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ew(input int w);
    case (w)
      0: return entry_word1;
      1: return entry_word2;
      2: return entry_word3;
      default: return entry_word4;
    endcase
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, got, RESP_OKAY);
    chk(got, 32'h0000_0000);
    for (int w = 0; w < 4; w++) begin
      rd(OFS_ENTRY1 + 16'(4 * w), got, RESP_OKAY);
      chk(got, RST_ENTRY);
    end
    rd(16'h0430, got, RESP_SLVERR);
    chk(got, 32'h0000_0000);
    wr(16'h0418, 32'hffff_ffff, RESP_SLVERR);
    // Reserved control bits stay zero, go written as zero starts nothing
    wr(OFS_CTRL, 32'hffff_ff7f, RESP_OKAY);
    rd(OFS_CTRL, got, RESP_OKAY);
    chk(got, 32'h003f_007f);
    chk(32'(tbl_req), 32'h0);
    for (int r = 0; r < 6; r++) begin
      row = rows[r];
      for (int w = 0; w < 4; w++) begin
        pre[w] = 32'ha000_0000 | 32'(r << 8) | 32'(w);
        rv[w] = 32'h5000_0000 | 32'(r << 8) | 32'(w);
        wr(OFS_ENTRY1 + 16'(4 * w), pre[w], RESP_OKAY);
      end
      ctrl = {10'h000, row.idx, 8'h00, 1'b1, row.spare, row.sel, row.rd};
      wr(OFS_CTRL, ctrl, RESP_OKAY);
      chk(32'(tbl_req), 32'h1);
      chk(32'(access_busy), 32'h1);
      chk(32'(tbl_sel), 32'(row.sel));
      chk(32'(tbl_rd), 32'(row.rd));
      chk(32'(tbl_index), row.sel ? 32'(row.idx) : 32'(row.idx[3:0]));
      chk(tbl_wdata1, row.sel ? 32'h0 : pre[0]);
      chk(tbl_wdata2, pre[1]);
      chk(tbl_wdata3, row.sel ? 32'h0 : pre[2]);
      chk(tbl_wdata4, row.sel ? 32'h0 : pre[3]);
      // Disturbances while busy must leave everything untouched
      wr(OFS_CTRL, ~ctrl, RESP_OKAY);
      wr(OFS_ENTRY1, 32'hbad0_0001, RESP_OKAY);
      @(posedge aclk);
      address_lookup_load <= 1'b1;
      address_lookup_word1 <= 32'hbad1_0001;
      address_lookup_word3 <= 32'hbad1_0003;
      @(posedge aclk);
      address_lookup_load <= 1'b0;
      rd(OFS_CTRL, got, RESP_OKAY);
      chk(got, ctrl);
      @(posedge aclk);
      tbl_ack <= 1'b1;
      {tbl_rdata1, tbl_rdata2, tbl_rdata3, tbl_rdata4} <= {rv[0], rv[1], rv[2], rv[3]};
      @(posedge aclk);
      tbl_ack <= 1'b0;
      {tbl_rdata1, tbl_rdata2, tbl_rdata3, tbl_rdata4} <= ~{rv[0], rv[1], rv[2], rv[3]};
      @(posedge aclk);
      chk(32'(tbl_req), 32'h0);
      chk(32'(access_busy), 32'h0);
      for (int w = 0; w < 4; w++) begin
        rd(OFS_ENTRY1 + 16'(4 * w), got, RESP_OKAY);
        chk(got, (row.rd && (!row.sel || w == 1)) ? rv[w] : pre[w]);
        chk(ew(w), got);
      end
      rd(OFS_CTRL, got, RESP_OKAY);
      chk(got, ctrl & 32'hffff_ff7f);
    end
    // Lookup engine load while idle shares the same entry registers
    @(posedge aclk);
    address_lookup_load <= 1'b1;
    {address_lookup_word1, address_lookup_word2} <= {32'hc000_0001, 32'hc000_0002};
    {address_lookup_word3, address_lookup_word4} <= {32'hc000_0003, 32'hc000_0004};
    @(posedge aclk);
    address_lookup_load <= 1'b0;
    for (int w = 0; w < 4; w++) begin
      rd(OFS_ENTRY1 + 16'(4 * w), got, RESP_OKAY);
      chk(got, 32'hc000_0001 + 32'(w));
    end
    // Clock enable low freezes a pending multicast read even with ack high
    wr(OFS_CTRL, 32'h0001_0083, RESP_OKAY);
    @(posedge aclk);
    ce <= 1'b0;
    tbl_ack <= 1'b1;
    tbl_rdata2 <= 32'h7e00_0002;
    repeat (3) @(posedge aclk);
    chk(32'(tbl_req), 32'h1);
    chk(32'(access_busy), 32'h1);
    chk(entry_word2, 32'hc000_0002);
    ce <= 1'b1;
    @(posedge aclk);
    tbl_ack <= 1'b0;
    @(posedge aclk);
    chk(32'(tbl_req), 32'h0);
    chk(32'(access_busy), 32'h0);
    chk(entry_word2, 32'h7e00_0002);
    // Reset in mid-run abandons a pending static write
    wr(OFS_CTRL, 32'h0005_0080, RESP_OKAY);
    chk(32'(tbl_req), 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(tbl_req), 32'h0);
    chk(32'(access_busy), 32'h0);
    chk(entry_word2, RST_ENTRY);
    rd(OFS_CTRL, got, RESP_OKAY);
    chk(got, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
